/* File: src/sysclk_mode_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sysclk_mode_power_ctrl #(
  parameter int PORTA_WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_osc_tick,
  input wire logic fast_osc_ready,
  input wire logic slow_osc_tick,
  input wire logic slow_osc_ready,
  input wire logic halt_req,
  input wire logic clr_wdt_req,
  input wire logic wdt_enable,
  input wire logic wdt_overflow,
  input wire logic [PORTA_WIDTH-1:0] porta_pins,
  input wire logic irq_request,
  input wire logic irq_enabled,
  input wire logic stack_full,
  output logic fast_osc_enable_out,
  output logic slow_osc_enable_out,
  output logic sys_clk_en,
  output logic cpu_halted,
  output sysclk_pkg::mode_e mode,
  output logic wdt_clear,
  output logic powerdown_flag,
  output logic wdt_timeout_flag,
  output logic wake,
  output sysclk_pkg::wake_s wake_info
);
  import sysclk_pkg::*;

  if (PORTA_WIDTH < 1 || PORTA_WIDTH > 8) begin : g_bad_width
    $error("PORTA_WIDTH must lie between 1 and 8");
  end

  sys_clk_ctrl_s system_clock_control;
  logic [2:0] sys_clk_select;
  logic fast_idle_enable;
  logic slow_idle_enable;
  logic fast_osc_enable;
  logic fast_osc_stable_flag;
  logic [PORTA_WIDTH-1:0] porta_wake_enable;
  logic [PORTA_WIDTH-1:0] porta_prev;
  logic [2:0] cur_sel;
  logic [5:0] div_cnt;
  logic irq_wake_blocked;
  logic halted;

  assign sys_clk_select = system_clock_control.sys_clk_select;
  assign fast_idle_enable = system_clock_control.fast_idle_enable;
  assign slow_idle_enable = system_clock_control.slow_idle_enable;

  // ---------------- AXI4-Lite slave ----------------
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  // Writable registers; the status word answers reads only.
  function automatic logic writable_addr(input logic [3:0] a);
    return (a == ADDR_SYS_CLK_CTRL) || (a == ADDR_FAST_OSC_CTRL) ||
           (a == ADDR_PORTA_WAKE);
  endfunction : writable_addr

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                   !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wr_hit = writable_addr(s_axi_awaddr);
  assign rd_hit = writable_addr(s_axi_araddr) ||
                  (s_axi_araddr == ADDR_STATUS);

  // Address and data are taken together so one write is never split.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0;
    case (s_axi_araddr)
      ADDR_SYS_CLK_CTRL: begin
        rd_word[7:0] = system_clock_control;
        rd_word[4:2] = 3'h0;
      end
      ADDR_FAST_OSC_CTRL: begin
        rd_word[FOC_STABLE_BIT] = fast_osc_stable_flag;
        rd_word[FOC_EN_BIT] = fast_osc_enable;
      end
      ADDR_PORTA_WAKE: rd_word[PORTA_WIDTH-1:0] = porta_wake_enable;
      ADDR_STATUS: rd_word[9:0] = {cur_sel, mode, wdt_timeout_flag,
                                   powerdown_flag, irq_wake_blocked,
                                   halted};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_fire && s_axi_wstrb[0];

  // Control registers. The idle bits are frozen while halted because
  // the CPU that would write them is stopped, and the oscillators must
  // not change under a low-power mode that has already been entered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_control.sys_clk_select <= SEL_RESET;
      system_clock_control.unused <= 3'h0;
      system_clock_control.fast_idle_enable <= FHI_RESET;
      system_clock_control.slow_idle_enable <= FSI_RESET;
      fast_osc_enable <= FOSC_EN_RESET;
      porta_wake_enable <= '0;
    end else if (wr_lane0) begin
      case (s_axi_awaddr)
        ADDR_SYS_CLK_CTRL: begin
          system_clock_control.sys_clk_select <=
            s_axi_wdata[SYS_CLK_SEL_LSB +: 3];
          if (!halted) begin
            system_clock_control.fast_idle_enable <=
              s_axi_wdata[FAST_IDLE_BIT];
            system_clock_control.slow_idle_enable <=
              s_axi_wdata[SLOW_IDLE_BIT];
          end
        end
        ADDR_FAST_OSC_CTRL: fast_osc_enable <= s_axi_wdata[FOC_EN_BIT];
        ADDR_PORTA_WAKE: porta_wake_enable <= s_axi_wdata[PORTA_WIDTH-1:0];
        default: system_clock_control.unused <= 3'h0;
      endcase
    end
  end

  // ---------------- Oscillator control ----------------
  logic fast_en_prev;
  logic next_fast_run;
  logic next_slow_run;

  always_comb begin
    next_fast_run = fast_osc_enable;
    next_slow_run = 1'b1;
    if (halted) begin
      next_fast_run = fast_osc_enable && fast_idle_enable;
      next_slow_run = slow_idle_enable || wdt_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_enable_out <= FOSC_EN_RESET;
      slow_osc_enable_out <= 1'b1;
    end else begin
      fast_osc_enable_out <= next_fast_run;
      slow_osc_enable_out <= next_slow_run;
    end
  end

  // A fresh enable first drops the flag; the oscillator must then report
  // ready again before the flag rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_stable_flag <= FOSC_STABLE_RESET;
      fast_en_prev <= 1'b0;
    end else begin
      fast_en_prev <= fast_osc_enable_out;
      if (!fast_osc_enable_out || (fast_osc_enable_out && !fast_en_prev)) begin
        fast_osc_stable_flag <= 1'b0;
      end else if (fast_osc_ready) begin
        fast_osc_stable_flag <= 1'b1;
      end
    end
  end

  // ---------------- System clock divider ----------------
  logic [5:0] div_mask;
  logic src_pulse;
  logic tgt_ok;
  logic may_switch;
  logic do_switch;

  assign div_mask = 6'((7'h1 << cur_sel) - 7'h1);
  assign src_pulse = (cur_sel == SEL_SLOW) ? slow_osc_tick :
                     (fast_osc_tick && ((div_cnt & div_mask) == div_mask));
  assign tgt_ok = (sys_clk_select == SEL_SLOW) ? slow_osc_ready :
                  fast_osc_stable_flag;
  // An old fast source that has lost its stable flag may never give the boundary, so it may be left.
  assign may_switch = src_pulse ||
                      ((cur_sel != SEL_SLOW) && !fast_osc_stable_flag);
  assign do_switch = (sys_clk_select != cur_sel) && tgt_ok && may_switch;

  // The selection changes at the end of an old period, or at once when an old
  // fast source has lost its stable flag, and the divider restarts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_sel <= SEL_SLOW;
      div_cnt <= 6'h0;
    end else if (do_switch) begin
      cur_sel <= sys_clk_select;
      div_cnt <= 6'h0;
    end else if (fast_osc_tick) begin
      div_cnt <= div_cnt + 6'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= src_pulse && !halted && !halt_req;
    end
  end

  // ---------------- Halt and wake-up ----------------
  logic halt_take;
  logic [PORTA_WIDTH-1:0] porta_fall;
  logic port_wake;
  logic irq_wake;
  logic wake_now;
  mode_e next_halt_mode;

  assign halt_take = halt_req && !halted;
  assign porta_fall = porta_prev & ~porta_pins;
  assign port_wake = |(porta_fall & porta_wake_enable);
  assign irq_wake = irq_request && !irq_wake_blocked;
  assign wake_now = halted && (port_wake || irq_wake || wdt_overflow);

  always_comb begin
    case ({fast_idle_enable, slow_idle_enable})
      2'b00: next_halt_mode = MODE_SLEEP;
      2'b01: next_halt_mode = MODE_IDLE_SLOW_ONLY;
      2'b11: next_halt_mode = MODE_IDLE_BOTH_CLOCKS;
      2'b10: next_halt_mode = MODE_IDLE_FAST_ONLY;
      default: next_halt_mode = MODE_SLEEP;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_prev <= '0;
    end else begin
      porta_prev <= porta_pins;
    end
  end

  // Halted covers every low-power mode; the core holds memory, registers
  // and port levels while it sees cpu_halted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted <= 1'b0;
      cpu_halted <= 1'b0;
      irq_wake_blocked <= 1'b0;
    end else if (halt_take) begin
      halted <= 1'b1;
      cpu_halted <= 1'b1;
      irq_wake_blocked <= irq_request;
    end else if (wake_now) begin
      halted <= 1'b0;
      cpu_halted <= 1'b0;
      irq_wake_blocked <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_SLOW;
    end else if (halt_take) begin
      mode <= next_halt_mode;
    end else if (!halted || wake_now) begin
      mode <= (cur_sel == SEL_SLOW) ? MODE_SLOW : MODE_NORMAL;
    end
  end

  // Halt entry wins over a clear in the same cycle, so the flag is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_flag <= POWERDOWN_RESET;
      wdt_timeout_flag <= TIMEOUT_RESET;
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= halt_take || clr_wdt_req;
      if (halt_take) begin
        powerdown_flag <= 1'b1;
      end else if (clr_wdt_req) begin
        powerdown_flag <= 1'b0;
      end
      if (wdt_overflow) begin
        wdt_timeout_flag <= 1'b1;
      end else if (halt_take) begin
        wdt_timeout_flag <= 1'b0;
      end
    end
  end

  // The watchdog cause takes precedence: it restarts the program counter
  // and stack pointer regardless of the other causes in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake <= 1'b0;
      wake_info <= '0;
    end else begin
      wake <= wake_now;
      wake_info <= '0;
      if (wake_now) begin
        if (wdt_overflow) begin
          wake_info.pc_sp_reset <= 1'b1;
        end else if (irq_wake && irq_enabled && !stack_full) begin
          wake_info.service_irq <= 1'b1;
        end else begin
          wake_info.resume_next <= 1'b1;
        end
      end
    end
  end

endmodule : sysclk_mode_power_ctrl
`default_nettype wire

/* File: src/sysclk_pkg.sv */
package sysclk_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] ADDR_SYS_CLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FAST_OSC_CTRL = 4'h4;
  localparam logic [3:0] ADDR_PORTA_WAKE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Field positions.
  localparam int SYS_CLK_SEL_LSB = 5;
  localparam int FAST_IDLE_BIT = 1;
  localparam int SLOW_IDLE_BIT = 0;
  localparam int FOC_STABLE_BIT = 1;
  localparam int FOC_EN_BIT = 0;

  // Reset values.
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic FHI_RESET = 1'b0;
  localparam logic FSI_RESET = 1'b0;
  localparam logic FOSC_EN_RESET = 1'b1;
  localparam logic FOSC_STABLE_RESET = 1'b0;
  localparam logic POWERDOWN_RESET = 1'b0;
  localparam logic TIMEOUT_RESET = 1'b0;

  // Clock select code that picks the slow oscillator.
  localparam logic [2:0] SEL_SLOW = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating modes, Gray coded in the order listed below.
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SLOW = 3'h1,
    MODE_SLEEP = 3'h3,
    MODE_IDLE_SLOW_ONLY = 3'h2,
    MODE_IDLE_BOTH_CLOCKS = 3'h6,
    MODE_IDLE_FAST_ONLY = 3'h7
  } mode_e;

  // System clock control register layout.
  typedef struct packed {
    logic [2:0] sys_clk_select;
    logic [2:0] unused;
    logic fast_idle_enable;
    logic slow_idle_enable;
  } sys_clk_ctrl_s;

  // Wake-up report towards the CPU core.
  typedef struct packed {
    logic resume_next;
    logic service_irq;
    logic pc_sp_reset;
  } wake_s;

endpackage : sysclk_pkg

/* File: tb/sysclk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sysclk_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_req,
  input wire logic clr_wdt_req,
  input wire logic wdt_enable,
  input wire logic wdt_overflow,
  input wire logic cpu_halted,
  input wire logic sys_clk_en,
  input wire sysclk_pkg::mode_e mode,
  input wire logic wdt_clear,
  input wire logic powerdown_flag,
  input wire logic wdt_timeout_flag,
  input wire logic wake,
  input wire sysclk_pkg::wake_s wake_info,
  input wire logic fast_osc_enable_out,
  input wire logic slow_osc_enable_out
);
  import sysclk_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence halt_taken;
    halt_req && !cpu_halted;
  endsequence
  // Two cycles in a mode let the oscillator enable flops catch up.
  sequence held_mode(mode_e m);
    mode == m ##1 mode == m;
  endsequence
  chk_halt_entry: assert property (halt_taken |=>
    cpu_halted && powerdown_flag && wdt_clear) else $error("halt entry");
  chk_halt_clears_to: assert property (
    halt_taken ##0 !wdt_overflow |=> !wdt_timeout_flag)
    else $error("timeout flag kept");
  chk_halt_stops_clk: assert property (
    cpu_halted |-> !sys_clk_en) else $error("clock runs while halted");
  chk_wdt_wake: assert property (
    cpu_halted && wdt_overflow |=>
    wake && wake_info.pc_sp_reset && wdt_timeout_flag)
    else $error("watchdog wake wrong");
  chk_wake_cause: assert property (
    wake |-> $past(cpu_halted) && !cpu_halted && $onehot(wake_info))
    else $error("bad wake pulse");
  chk_wdt_slow_on: assert property (
    wdt_enable ##1 wdt_enable |-> slow_osc_enable_out)
    else $error("slow oscillator off with watchdog");
  chk_clr_pdf: assert property (
    clr_wdt_req && !halt_req && !cpu_halted |=> !powerdown_flag)
    else $error("powerdown flag not cleared");
  chk_sleep_fast_off: assert property (
    held_mode(MODE_SLEEP) |-> !fast_osc_enable_out)
    else $error("fast oscillator on in sleep");
  chk_idle_both_on: assert property (
    held_mode(MODE_IDLE_BOTH_CLOCKS) |->
    fast_osc_enable_out && slow_osc_enable_out)
    else $error("oscillator off in idle");
  chk_halt_holds: assert property (
    cpu_halted ##1 cpu_halted |-> powerdown_flag && $stable(mode))
    else $error("state moved while halted");
endmodule : sysclk_asserts
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sysclk_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic fast_osc_tick = 1'b0, fast_osc_ready = 1'b1, slow_osc_tick = 1'b0;
  logic slow_osc_ready = 1'b1, halt_req = 1'b0, clr_wdt_req = 1'b0;
  logic wdt_enable = 1'b0, wdt_overflow = 1'b0, irq_request = 1'b0;
  logic irq_enabled = 1'b1, stack_full = 1'b0;
  logic [7:0] porta_pins = 8'hff;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic fast_osc_enable_out, slow_osc_enable_out, sys_clk_en, cpu_halted;
  logic wdt_clear, powerdown_flag, wdt_timeout_flag, wake;
  mode_e mode;
  wake_s wake_info;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [3:0] ph = 4'h0;

  sysclk_mode_power_ctrl sysclk_mode_power_ctrl_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .fast_osc_tick(fast_osc_tick),
    .fast_osc_ready(fast_osc_ready),
    .slow_osc_tick(slow_osc_tick),
    .slow_osc_ready(slow_osc_ready),
    .halt_req(halt_req),
    .clr_wdt_req(clr_wdt_req),
    .wdt_enable(wdt_enable),
    .wdt_overflow(wdt_overflow),
    .porta_pins(porta_pins),
    .irq_request(irq_request),
    .irq_enabled(irq_enabled),
    .stack_full(stack_full),
    .fast_osc_enable_out(fast_osc_enable_out),
    .slow_osc_enable_out(slow_osc_enable_out),
    .sys_clk_en(sys_clk_en),
    .cpu_halted(cpu_halted),
    .mode(mode),
    .wdt_clear(wdt_clear),
    .powerdown_flag(powerdown_flag),
    .wdt_timeout_flag(wdt_timeout_flag),
    .wake(wake),
    .wake_info(wake_info)
  );

  always #12.5 aclk = ~aclk;

  // Fast ticks every second cycle and slow ticks every sixteenth keep
  // each divider period short enough to measure exactly.
  always @(posedge aclk) begin
    ph <= ph + 4'h1;
    fast_osc_tick <= ph[0];
    slow_osc_tick <= (ph == 4'hf);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask : wr

  // Every aligned word of the map is a register; anything else is refused.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp},
        {30'h0, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR});
    s_axi_rready <= 1'b0;
  endtask : rd

  // The last gap of four is taken so that a switch in flight is settled.
  task automatic period(input int e);
    int n = 0;
    for (int p = 0; p < 4; p++) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (sys_clk_en !== 1'b1 && n < 300);
    end
    chk(n, e);
  endtask : period

  task automatic halt;
    @(posedge aclk);
    halt_req <= 1'b1;
    @(posedge aclk);
    halt_req <= 1'b0;
    #1;
  endtask : halt

  // The short step first lets a wake launched at this very edge settle.
  task automatic wait_wake(input logic [2:0] e);
    int n = 0;
    #1;
    while (wake !== 1'b1 && n < 40) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk({29'h0, wake_info}, {29'h0, e});
    chk({31'h0, cpu_halted}, 32'h0);
  endtask : wait_wake

  task automatic t_regs;
    rd(ADDR_SYS_CLK_CTRL, 8'h00);
    rd(ADDR_FAST_OSC_CTRL, 8'h03);
    wr(ADDR_SYS_CLK_CTRL, 8'hfc, RESP_OKAY);
    rd(ADDR_SYS_CLK_CTRL, 8'he0);
    wr(ADDR_STATUS, 8'h00, RESP_SLVERR);
    rd(4'h2, 8'h00);
  endtask : t_regs

  task automatic t_clk;
    @(posedge aclk);
    fast_osc_ready <= 1'b0;
    wr(ADDR_FAST_OSC_CTRL, 8'h00, RESP_OKAY);
    rd(ADDR_FAST_OSC_CTRL, 8'h00);
    chk({31'h0, fast_osc_enable_out}, 32'h0);
    wr(ADDR_FAST_OSC_CTRL, 8'h01, RESP_OKAY);
    rd(ADDR_FAST_OSC_CTRL, 8'h01);
    wr(ADDR_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    period(16);
    @(posedge aclk);
    fast_osc_ready <= 1'b1;
    rd(ADDR_FAST_OSC_CTRL, 8'h03);
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_SYS_CLK_CTRL, {c[2:0], 5'h0}, RESP_OKAY);
      period(2 << c);
    end
    @(posedge aclk);
    slow_osc_ready <= 1'b0;
    wr(ADDR_SYS_CLK_CTRL, 8'he0, RESP_OKAY);
    period(128);
    @(posedge aclk);
    slow_osc_ready <= 1'b1;
    period(16);
  endtask : t_clk

  task automatic t_halt;
    mode_e m [4] = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY,
                     MODE_IDLE_BOTH_CLOCKS};
    wr(ADDR_PORTA_WAKE, 8'h01, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SYS_CLK_CTRL, {6'h0, i[1:0]}, RESP_OKAY);
      halt;
      chk({29'h0, mode}, {29'h0, m[i]});
      chk({30'h0, powerdown_flag, wdt_timeout_flag}, 32'h2);
      repeat (3) @(posedge aclk);
      #1;
      chk({30'h0, fast_osc_enable_out, slow_osc_enable_out},
          {30'h0, i[1:0]});
      @(posedge aclk);
      porta_pins <= 8'hfd;
      @(posedge aclk);
      porta_pins <= 8'hff;
      repeat (3) @(posedge aclk);
      #1;
      chk({31'h0, cpu_halted}, 32'h1);
      @(posedge aclk);
      porta_pins <= 8'hfe;
      wait_wake(3'h4);
      @(posedge aclk);
      porta_pins <= 8'hff;
    end
  endtask : t_halt

  task automatic t_wdt;
    @(posedge aclk);
    wdt_enable <= 1'b1;
    wr(ADDR_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    halt;
    repeat (3) @(posedge aclk);
    #1;
    chk({31'h0, slow_osc_enable_out}, 32'h1);
    @(posedge aclk);
    wdt_overflow <= 1'b1;
    @(posedge aclk);
    wdt_overflow <= 1'b0;
    wait_wake(3'h1);
    chk({30'h0, powerdown_flag, wdt_timeout_flag}, 32'h3);
    @(posedge aclk);
    clr_wdt_req <= 1'b1;
    @(posedge aclk);
    clr_wdt_req <= 1'b0;
    wdt_enable <= 1'b0;
    #1;
    chk({31'h0, powerdown_flag}, 32'h0);
  endtask : t_wdt

  task automatic irq_wake(input logic en, input logic full,
                          input logic [2:0] e);
    @(posedge aclk);
    irq_enabled <= en;
    stack_full <= full;
    halt;
    @(posedge aclk);
    irq_request <= 1'b1;
    wait_wake(e);
    @(posedge aclk);
    irq_request <= 1'b0;
  endtask : irq_wake

  task automatic t_irq;
    irq_wake(1'b1, 1'b0, 3'h2);
    irq_wake(1'b0, 1'b0, 3'h4);
    irq_wake(1'b1, 1'b1, 3'h4);
    @(posedge aclk);
    irq_request <= 1'b1;
    stack_full <= 1'b0;
    halt;
    repeat (5) @(posedge aclk);
    #1;
    chk({31'h0, cpu_halted}, 32'h1);
    chk({31'h0, wdt_timeout_flag}, 32'h0);
    @(posedge aclk);
    porta_pins <= 8'hfe;
    wait_wake(3'h4);
    @(posedge aclk);
    porta_pins <= 8'hff;
    irq_request <= 1'b0;
  endtask : t_irq

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_clk;
    t_halt;
    t_wdt;
    t_irq;
    print_verdict;
  end
endmodule : tb

bind sysclk_mode_power_ctrl sysclk_asserts sysclk_asserts_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .halt_req(halt_req),
  .clr_wdt_req(clr_wdt_req),
  .wdt_enable(wdt_enable),
  .wdt_overflow(wdt_overflow),
  .cpu_halted(cpu_halted),
  .sys_clk_en(sys_clk_en),
  .mode(mode),
  .wdt_clear(wdt_clear),
  .powerdown_flag(powerdown_flag),
  .wdt_timeout_flag(wdt_timeout_flag),
  .wake(wake),
  .wake_info(wake_info),
  .fast_osc_enable_out(fast_osc_enable_out),
  .slow_osc_enable_out(slow_osc_enable_out)
);
`default_nettype wire
